// >>> acdrc_top.v
// record clock dividers, oversampling and dsp rate registers on avalon-mm
// Function
// - playback upsample factor 4 bits, zero means 16, reset 8, used when dsp active
// - record core divider: power bit 7, ratio zero 128, off follows playback core
// - record modulator divider: power bit 7, ratio zero 128, off follows playback mod
// - record oversampling ratio 8 bits, zero means 256, reset 128
// - 15-bit instruction budget, upper 7 bits first register, zero 32768, reset 1/0
// - upper budget write staged, applied only if next write hits lower register
// - record decimation factor 4 bits, zero means 16, reset 4, used when dsp active
// - reserved bits read zero, are read-only, software writes zeros
`timescale 1ns/1ns
`include "acdrc_consts.vh"

module acdrc_top (
    input  wire        CORE_CLK,
    input  wire        ARST_N,
    input  wire [7:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output wire        AVS_WAITREQUEST,
    input  wire        PLAYBACK_CORE_CLOCK,
    input  wire        PLAYBACK_MODULATOR_CLOCK,
    input  wire        DAC_DSP_ACTIVE,
    input  wire        ADC_DSP_ACTIVE,
    output wire        RECORD_CORE_CLOCK,
    output wire        RECORD_MODULATOR_CLOCK,
    output reg  [4:0]  DAC_DSP_UPSAMPLE_FACTOR,
    output reg  [4:0]  ADC_DSP_DOWNSAMPLE_FACTOR,
    output reg  [8:0]  ADC_OVERSAMPLING_RATIO,
    output reg  [15:0] ADC_DSP_INSTRUCTION_BUDGET,
    output reg  [7:0]  ADC_CORE_DIVIDER,
    output reg  [7:0]  ADC_MODULATOR_DIVIDER
);

    // ------------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------------
    // four-bit rate code where zero stands for sixteen
    function [4:0] decode_factor;
        input [3:0] code;
        begin
            decode_factor = (code == 4'h0) ? `ACDRC_FACTOR_ZERO_VAL : {1'b0, code};
        end
    endfunction

    // seven-bit divider code where zero stands for 128
    function [7:0] decode_ratio;
        input [6:0] code;
        begin
            decode_ratio = (code == 7'h00) ? `ACDRC_RATIO_ZERO_VAL : {1'b0, code};
        end
    endfunction

    // true when the index addresses the staged upper budget register
    function is_budget_hi;
        input [5:0] index;
        begin
            is_budget_hi = (index == `ACDRC_IDX_BUDGET_HI);
        end
    endfunction

    // ------------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------------
    reg         ack_q;
    reg         ack_d;
    wire        req;
    wire        wr_fire;
    wire        wr_lane0;
    wire        rd_load;
    wire [5:0]  idx;
    wire [7:0]  wdata;

    // every request waits one cycle, then completes with waitrequest low;
    // the master must keep address, direction and data steady meanwhile,
    // since the write is taken only in the cycle with waitrequest low
    assign req             = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~ack_q;
    assign wr_fire         = AVS_WRITE & ack_q;
    assign wr_lane0        = wr_fire & AVS_BYTEENABLE[0];
    assign rd_load         = AVS_READ & ~ack_q;
    assign idx             = AVS_ADDRESS[`ACDRC_ADDR_IDX_MSB:`ACDRC_ADDR_IDX_LSB];
    assign wdata           = AVS_WRITEDATA[7:0];

    // acknowledge toggles so back-to-back requests each see one wait cycle;
    // a request still held after its answer starts a fresh access
    always @* begin
        ack_d = req & ~ack_q;
    end

    // ------------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------------
    reg  [7:0]  upsample_q;
    reg  [7:0]  core_div_q;
    reg  [7:0]  mod_div_q;
    reg  [7:0]  oversample_q;
    reg  [7:0]  budget_hi_stage_q;
    reg  [7:0]  budget_hi_act_q;
    reg  [7:0]  budget_lo_q;
    reg  [7:0]  downsample_q;
    reg         pending_q;
    reg         pending_d;

    // staged upper budget survives only until the next write command;
    // any accepted write counts, even one with byte lane zero disabled,
    // so software cannot slip a command between the two budget halves;
    // reads leave the staging untouched
    always @* begin
        pending_d = pending_q;
        if (wr_fire) begin
            pending_d = is_budget_hi(idx);
        end
    end

    // register writes; reserved bits are masked off so they stay zero
    // byte lane zero carries every register, the upper lanes are ignored
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_q             <= 1'b0;
            upsample_q        <= `ACDRC_RST_UPSAMPLE;
            core_div_q        <= `ACDRC_RST_CORE_DIV;
            mod_div_q         <= `ACDRC_RST_MOD_DIV;
            oversample_q      <= `ACDRC_RST_OVERSAMPLE;
            budget_hi_stage_q <= `ACDRC_RST_BUDGET_HI;
            budget_hi_act_q   <= `ACDRC_RST_BUDGET_HI;
            budget_lo_q       <= `ACDRC_RST_BUDGET_LO;
            downsample_q      <= `ACDRC_RST_DOWNSAMPLE;
            pending_q         <= 1'b0;
        end else begin
            ack_q     <= ack_d;
            pending_q <= pending_d;
            if (wr_lane0) begin
                case (idx)
                    `ACDRC_IDX_UPSAMPLE: begin
                        upsample_q <= wdata & `ACDRC_MASK_FACTOR;
                    end
                    `ACDRC_IDX_CORE_DIV: begin
                        core_div_q <= wdata;
                    end
                    `ACDRC_IDX_MOD_DIV: begin
                        mod_div_q <= wdata;
                    end
                    `ACDRC_IDX_OVERSAMPLE: begin
                        oversample_q <= wdata;
                    end
                    `ACDRC_IDX_BUDGET_HI: begin
                        budget_hi_stage_q <= wdata & `ACDRC_MASK_BUDGET_HI;
                    end
                    `ACDRC_IDX_BUDGET_LO: begin
                        budget_lo_q <= wdata;
                    end
                    `ACDRC_IDX_DOWNSAMPLE: begin
                        downsample_q <= wdata & `ACDRC_MASK_FACTOR;
                    end
                    default: begin
                        upsample_q <= upsample_q;  // reserved and unmapped: ignored
                    end
                endcase
            end
            // commit or drop the staged upper budget on the following write;
            // a dropped stage reloads the committed copy so reads agree with it,
            // while a repeated upper write simply replaces the stage
            if (wr_fire && pending_q) begin
                if (idx == `ACDRC_IDX_BUDGET_LO) begin
                    budget_hi_act_q <= budget_hi_stage_q;
                end else if (!is_budget_hi(idx)) begin
                    budget_hi_stage_q <= budget_hi_act_q;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------------
    reg  [7:0]  rd_byte;
    wire [7:0]  status_byte;

    // live state visible to software
    // bit 0 shows a staged upper budget still waiting for its lower half
    assign status_byte = {3'b000,
                          DAC_DSP_ACTIVE,
                          ADC_DSP_ACTIVE,
                          mod_div_q[`ACDRC_PWR_BIT],
                          core_div_q[`ACDRC_PWR_BIT],
                          pending_q};

    // byte mux; reserved register and unmapped addresses read zero
    always @* begin
        case (idx)
            `ACDRC_IDX_UPSAMPLE:   rd_byte = upsample_q;
            `ACDRC_IDX_CORE_DIV:   rd_byte = core_div_q;
            `ACDRC_IDX_MOD_DIV:    rd_byte = mod_div_q;
            `ACDRC_IDX_OVERSAMPLE: rd_byte = oversample_q;
            `ACDRC_IDX_BUDGET_HI:  rd_byte = budget_hi_stage_q;
            `ACDRC_IDX_BUDGET_LO:  rd_byte = budget_lo_q;
            `ACDRC_IDX_DOWNSAMPLE: rd_byte = downsample_q;
            `ACDRC_IDX_RESERVED:   rd_byte = `ACDRC_RST_ZERO8;
            `ACDRC_IDX_STATUS:     rd_byte = status_byte;
            default:               rd_byte = `ACDRC_RST_ZERO8;
        endcase
    end

    // read data is loaded in the wait cycle and held until the next read;
    // loading early keeps the data path registered while the answer is
    // still one cycle after the request
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            AVS_READDATA <= `ACDRC_RST_ZERO32;
        end else if (rd_load) begin
            AVS_READDATA <= {24'h00_0000, rd_byte};  // upper lanes read zero
        end
    end

    // ------------------------------------------------------------------------
    // record clock dividers
    // ------------------------------------------------------------------------
    wire [1:0]  src_tick;
    wire [15:0] div_cfg;
    wire [1:0]  rec_tick;

    assign src_tick = {PLAYBACK_MODULATOR_CLOCK, PLAYBACK_CORE_CLOCK};
    assign div_cfg  = {mod_div_q, core_div_q};

    // index 0 makes the record core clock, index 1 the modulator clock;
    // a powered-down divider passes its playback tick through, so the
    // record clock then equals the playback clock one cycle later
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_div
            acdrc_divider u_div (
                .clk      (CORE_CLK),
                .arst_n   (ARST_N),
                .power_up (div_cfg[g*8+`ACDRC_PWR_BIT]),
                .ratio    (div_cfg[g*8+`ACDRC_RATIO_MSB -: 7]),
                .src_tick (src_tick[g]),
                .div_tick (rec_tick[g])
            );
        end
    endgenerate

    assign RECORD_CORE_CLOCK      = rec_tick[0];
    assign RECORD_MODULATOR_CLOCK = rec_tick[1];

    // ------------------------------------------------------------------------
    // effective rate outputs
    // ------------------------------------------------------------------------
    reg  [4:0]  upsample_eff_d;
    reg  [4:0]  downsample_eff_d;
    reg  [8:0]  oversample_eff_d;
    reg  [15:0] budget_eff_d;
    wire [14:0] budget_raw;

    // committed budget word, upper seven bits from the active copy only
    assign budget_raw = {budget_hi_act_q[`ACDRC_RATIO_MSB:0], budget_lo_q};

    // dsp factors pass through only while the matching processor is active;
    // a neutral factor of one keeps idle rate logic off stale codes
    always @* begin
        upsample_eff_d   = `ACDRC_FACTOR_NEUTRAL;
        downsample_eff_d = `ACDRC_FACTOR_NEUTRAL;
        if (DAC_DSP_ACTIVE) begin
            upsample_eff_d = decode_factor(upsample_q[`ACDRC_FACTOR_MSB:0]);
        end
        if (ADC_DSP_ACTIVE) begin
            downsample_eff_d = decode_factor(downsample_q[`ACDRC_FACTOR_MSB:0]);
        end
        // zero code stands for 256
        if (oversample_q == `ACDRC_RST_ZERO8) begin
            oversample_eff_d = `ACDRC_OSR_ZERO_VAL;
        end else begin
            oversample_eff_d = {1'b0, oversample_q};
        end
        // zero budget stands for 32768
        if (budget_raw == 15'h0000) begin
            budget_eff_d = `ACDRC_BUDGET_ZERO_VAL;
        end else begin
            budget_eff_d = {1'b0, budget_raw};
        end
    end

    // outputs lag the register contents by one cycle
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DAC_DSP_UPSAMPLE_FACTOR    <= `ACDRC_FACTOR_NEUTRAL;
            ADC_DSP_DOWNSAMPLE_FACTOR  <= `ACDRC_FACTOR_NEUTRAL;
            ADC_OVERSAMPLING_RATIO     <= `ACDRC_RST_OSR_OUT;
            ADC_DSP_INSTRUCTION_BUDGET <= `ACDRC_RST_BUDGET_OUT;
            ADC_CORE_DIVIDER           <= `ACDRC_RST_DIV_OUT;
            ADC_MODULATOR_DIVIDER      <= `ACDRC_RST_DIV_OUT;
        end else begin
            DAC_DSP_UPSAMPLE_FACTOR    <= upsample_eff_d;
            ADC_DSP_DOWNSAMPLE_FACTOR  <= downsample_eff_d;
            ADC_OVERSAMPLING_RATIO     <= oversample_eff_d;
            ADC_DSP_INSTRUCTION_BUDGET <= budget_eff_d;
            ADC_CORE_DIVIDER           <= decode_ratio(core_div_q[`ACDRC_RATIO_MSB:0]);
            ADC_MODULATOR_DIVIDER      <= decode_ratio(mod_div_q[`ACDRC_RATIO_MSB:0]);
        end
    end

endmodule // acdrc_top

// >>> acdrc_consts.vh
// constants for the record clock divider and dsp rate configuration block
`ifndef ACDRC_CONSTS_VH
`define ACDRC_CONSTS_VH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define ACDRC_IDX_W              6
`define ACDRC_IDX_UPSAMPLE       6'h11
`define ACDRC_IDX_CORE_DIV       6'h12
`define ACDRC_IDX_MOD_DIV        6'h13
`define ACDRC_IDX_OVERSAMPLE     6'h14
`define ACDRC_IDX_BUDGET_HI      6'h15
`define ACDRC_IDX_BUDGET_LO      6'h16
`define ACDRC_IDX_DOWNSAMPLE     6'h17
`define ACDRC_IDX_RESERVED       6'h18
`define ACDRC_IDX_STATUS         6'h1F

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ACDRC_RST_UPSAMPLE       8'h08
`define ACDRC_RST_CORE_DIV       8'h01
`define ACDRC_RST_MOD_DIV        8'h01
`define ACDRC_RST_OVERSAMPLE     8'h80
`define ACDRC_RST_BUDGET_HI      8'h01
`define ACDRC_RST_BUDGET_LO      8'h00
`define ACDRC_RST_DOWNSAMPLE     8'h04
`define ACDRC_RST_ZERO8          8'h00
`define ACDRC_RST_ZERO32         32'h0000_0000

// ----------------------------------------------------------------------------
// field layout and writable masks
// ----------------------------------------------------------------------------
`define ACDRC_PWR_BIT            7
`define ACDRC_RATIO_MSB          6
`define ACDRC_FACTOR_MSB         3
`define ACDRC_MASK_FACTOR        8'h0F
`define ACDRC_MASK_BUDGET_HI     8'h7F
`define ACDRC_MASK_FULL          8'hFF
`define ACDRC_ADDR_IDX_LSB       2
`define ACDRC_ADDR_IDX_MSB       7

// ----------------------------------------------------------------------------
// status register bit positions
// ----------------------------------------------------------------------------
`define ACDRC_ST_PENDING         0
`define ACDRC_ST_CORE_PWR        1
`define ACDRC_ST_MOD_PWR         2
`define ACDRC_ST_ADC_DSP         3
`define ACDRC_ST_DAC_DSP         4

// ----------------------------------------------------------------------------
// divider counter
// ----------------------------------------------------------------------------
`define ACDRC_CNT_ZERO           7'h00
`define ACDRC_CNT_ONE            7'h01

// ----------------------------------------------------------------------------
// decoded zero codes and output reset values
// ----------------------------------------------------------------------------
`define ACDRC_FACTOR_ZERO_VAL    5'h10
`define ACDRC_RATIO_ZERO_VAL     8'h80
`define ACDRC_OSR_ZERO_VAL       9'h100
`define ACDRC_BUDGET_ZERO_VAL    16'h8000
`define ACDRC_FACTOR_NEUTRAL     5'h01
`define ACDRC_RST_OSR_OUT        9'h080
`define ACDRC_RST_BUDGET_OUT     16'h0100
`define ACDRC_RST_DIV_OUT        8'h01

`endif

// >>> acdrc_divider.v
// record clock divider with power control and fallback to the playback clock
`timescale 1ns/1ns
`include "acdrc_consts.vh"

module acdrc_divider (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       power_up,
    input  wire [6:0] ratio,
    input  wire       src_tick,
    output reg        div_tick
);

    reg  [6:0] cnt_q;
    reg  [6:0] cnt_d;
    wire [6:0] terminal;
    wire       wrap;

    // ratio code zero wraps to 127, giving a divide by 128
    assign terminal = ratio - `ACDRC_CNT_ONE;
    assign wrap     = (cnt_q == terminal);

    // ------------------------------------------------------------------------
    // tick counter
    // ------------------------------------------------------------------------
    // counter is held at zero while powered down so a power-up starts clean
    always @* begin
        cnt_d = cnt_q;
        if (!power_up) begin
            cnt_d = `ACDRC_CNT_ZERO;
        end else if (src_tick) begin
            cnt_d = wrap ? `ACDRC_CNT_ZERO : cnt_q + `ACDRC_CNT_ONE;
        end
    end

    // output tick follows the source when powered down, else every n ticks
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q    <= `ACDRC_CNT_ZERO;
            div_tick <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            div_tick <= power_up ? (src_tick & wrap) : src_tick;
        end
    end

endmodule // acdrc_divider

// >>> acdrc_properties.sv
// concurrent checks on the ports of the record clock and dsp rate block
`timescale 1ns/1ns
`include "acdrc_consts.vh"
module acdrc_properties (
    input wire        CORE_CLK,
    input wire        ARST_N,
    input wire [7:0]  AVS_ADDRESS,
    input wire        AVS_READ,
    input wire        AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0]  AVS_BYTEENABLE,
    input wire [31:0] AVS_READDATA,
    input wire        AVS_WAITREQUEST,
    input wire        PLAYBACK_CORE_CLOCK,
    input wire        PLAYBACK_MODULATOR_CLOCK,
    input wire        DAC_DSP_ACTIVE,
    input wire        ADC_DSP_ACTIVE,
    input wire        RECORD_CORE_CLOCK,
    input wire        RECORD_MODULATOR_CLOCK,
    input wire [4:0]  DAC_DSP_UPSAMPLE_FACTOR,
    input wire [4:0]  ADC_DSP_DOWNSAMPLE_FACTOR,
    input wire [8:0]  ADC_OVERSAMPLING_RATIO,
    input wire [15:0] ADC_DSP_INSTRUCTION_BUDGET,
    input wire [7:0]  ADC_CORE_DIVIDER,
    input wire [7:0]  ADC_MODULATOR_DIVIDER
);
// accepted bus cycles, decoded index and written byte
wire       wacc = AVS_WRITE & ~AVS_WAITREQUEST;
wire       acc  = wacc & AVS_BYTEENABLE[0];
wire       racc = AVS_READ & ~AVS_WAITREQUEST;
wire [5:0] idx  = AVS_ADDRESS[7:2];
wire [7:0] wd   = AVS_WRITEDATA[7:0];
reg        core_pwr_q;
reg        mod_pwr_q;
// shadow of the divider power bits, taken from accepted writes
always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        core_pwr_q <= 1'b0;
        mod_pwr_q  <= 1'b0;
    end else if (acc) begin
        if (idx == `ACDRC_IDX_CORE_DIV) core_pwr_q <= wd[7];
        if (idx == `ACDRC_IDX_MOD_DIV) mod_pwr_q <= wd[7];
    end
end
default clocking cb @(posedge CORE_CLK); endclocking
default disable iff (!ARST_N);
upsample_rsvd_a: assert property (
    racc && idx == `ACDRC_IDX_UPSAMPLE |-> AVS_READDATA[31:4] == 28'h000_0000)
    else $error("reserved upsample bits read nonzero");
core_follow_a: assert property (
    !core_pwr_q && !$past(core_pwr_q) && !$past(core_pwr_q, 2) |->
    RECORD_CORE_CLOCK == $past(PLAYBACK_CORE_CLOCK))
    else $error("record core clock not following playback core clock");
mod_follow_a: assert property (
    !mod_pwr_q && !$past(mod_pwr_q) && !$past(mod_pwr_q, 2) |->
    RECORD_MODULATOR_CLOCK == $past(PLAYBACK_MODULATOR_CLOCK))
    else $error("record modulator clock not following playback clock");
core_source_a: assert property (
    RECORD_CORE_CLOCK |-> $past(PLAYBACK_CORE_CLOCK))
    else $error("record core tick without a source tick");
osr_decode_a: assert property (
    $past(acc, 2) && $past(idx, 2) == `ACDRC_IDX_OVERSAMPLE |->
    ADC_OVERSAMPLING_RATIO == ($past(wd, 2) == 8'h00 ? 9'h100 : {1'b0, $past(wd, 2)}))
    else $error("oversampling ratio does not match written code");
core_decode_a: assert property (
    $past(acc, 2) && $past(idx, 2) == `ACDRC_IDX_CORE_DIV |->
    ADC_CORE_DIVIDER == ($past(wd[6:0], 2) == 7'h00 ? 8'h80 : {1'b0, $past(wd[6:0], 2)}))
    else $error("core divider ratio does not match written code");
budget_commit_a: assert property (
    $changed(ADC_DSP_INSTRUCTION_BUDGET) |-> $past(wacc, 2) && $past(idx, 2) == `ACDRC_IDX_BUDGET_LO)
    else $error("budget changed without a lower budget write");
dac_idle_a: assert property (
    !DAC_DSP_ACTIVE |=> DAC_DSP_UPSAMPLE_FACTOR == 5'h01)
    else $error("upsample factor applied while playback dsp idle");
adc_idle_a: assert property (
    !ADC_DSP_ACTIVE |=> ADC_DSP_DOWNSAMPLE_FACTOR == 5'h01)
    else $error("downsample factor applied while record dsp idle");
// main scenarios reached
budget_lo_c: cover property (wacc && idx == `ACDRC_IDX_BUDGET_LO);
core_tick_c: cover property (RECORD_CORE_CLOCK && core_pwr_q);
rsvd_read_c: cover property (racc && idx == `ACDRC_IDX_RESERVED);
endmodule // acdrc_properties

// >>> tb.sv
// self-checking bench for the record clock and dsp rate block
`timescale 1ns/1ns
bind acdrc_top acdrc_properties u_props (.CORE_CLK, .ARST_N, .AVS_ADDRESS, .AVS_READ,
    .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .PLAYBACK_CORE_CLOCK, .PLAYBACK_MODULATOR_CLOCK, .DAC_DSP_ACTIVE, .ADC_DSP_ACTIVE,
    .RECORD_CORE_CLOCK, .RECORD_MODULATOR_CLOCK, .DAC_DSP_UPSAMPLE_FACTOR,
    .ADC_DSP_DOWNSAMPLE_FACTOR, .ADC_OVERSAMPLING_RATIO, .ADC_DSP_INSTRUCTION_BUDGET,
    .ADC_CORE_DIVIDER, .ADC_MODULATOR_DIVIDER);
module tb;
reg         CORE_CLK = 1'b0;
reg         ARST_N = 1'b0;
reg  [7:0]  AVS_ADDRESS = 8'h00;
reg         AVS_READ = 1'b0;
reg         AVS_WRITE = 1'b0;
reg  [31:0] AVS_WRITEDATA = 32'h0000_0000;
reg  [3:0]  AVS_BYTEENABLE = 4'h0;
reg         PLAYBACK_CORE_CLOCK = 1'b0;
reg         PLAYBACK_MODULATOR_CLOCK = 1'b0;
reg         DAC_DSP_ACTIVE = 1'b0;
reg         ADC_DSP_ACTIVE = 1'b0;
wire [31:0] AVS_READDATA;
wire        AVS_WAITREQUEST;
wire        RECORD_CORE_CLOCK;
wire        RECORD_MODULATOR_CLOCK;
wire [4:0]  DAC_DSP_UPSAMPLE_FACTOR;
wire [4:0]  ADC_DSP_DOWNSAMPLE_FACTOR;
wire [8:0]  ADC_OVERSAMPLING_RATIO;
wire [15:0] ADC_DSP_INSTRUCTION_BUDGET;
wire [7:0]  ADC_CORE_DIVIDER;
wire [7:0]  ADC_MODULATOR_DIVIDER;
reg         tick_en = 1'b0;
reg  [31:0] q;
reg  [7:0]  k;
integer     core_cnt = 0;
integer     mod_cnt = 0;
integer     error_cnt = 0;
integer     checks_done = 0;
// register reset table, index 0x18 down to 0x11
localparam [63:0] RST = 64'h0004_0001_8001_0108;
acdrc_top u_dut (.CORE_CLK, .ARST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .PLAYBACK_CORE_CLOCK,
    .PLAYBACK_MODULATOR_CLOCK, .DAC_DSP_ACTIVE, .ADC_DSP_ACTIVE, .RECORD_CORE_CLOCK,
    .RECORD_MODULATOR_CLOCK, .DAC_DSP_UPSAMPLE_FACTOR, .ADC_DSP_DOWNSAMPLE_FACTOR,
    .ADC_OVERSAMPLING_RATIO, .ADC_DSP_INSTRUCTION_BUDGET, .ADC_CORE_DIVIDER,
    .ADC_MODULATOR_DIVIDER);
always #50 CORE_CLK = ~CORE_CLK;
// playback ticks every second cycle, record ticks counted
always @(posedge CORE_CLK) begin
    PLAYBACK_CORE_CLOCK <= tick_en & ~PLAYBACK_CORE_CLOCK;
    PLAYBACK_MODULATOR_CLOCK <= tick_en & ~PLAYBACK_CORE_CLOCK;
    if (RECORD_CORE_CLOCK === 1'b1) core_cnt = core_cnt + 1;
    if (RECORD_MODULATOR_CLOCK === 1'b1) mod_cnt = mod_cnt + 1;
end
task report_and_stop;
begin
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
end
endtask
task chk(input [31:0] got, input [31:0] exp);
begin
    checks_done = checks_done + 1;
    if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
end
endtask
// one avalon cycle, called just after a rising edge: held until waitrequest
// is sampled low at a rising edge, data taken and request dropped there
task bus(input w, input [5:0] i, input [7:0] d, input be);
begin
    AVS_ADDRESS <= {i, 2'b00};
    AVS_WRITEDATA <= {24'h00_0000, d};
    AVS_BYTEENABLE <= {4{be}};
    AVS_WRITE <= w;
    AVS_READ <= ~w;
    @(posedge CORE_CLK);
    while (AVS_WAITREQUEST !== 1'b0) @(posedge CORE_CLK);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CORE_CLK);
end
endtask
task wr(input [5:0] i, input [7:0] d);
    bus(1'b1, i, d, 1'b1);
endtask
task rd(input [5:0] i, input [7:0] e);
begin
    bus(1'b0, i, 8'h00, 1'b1);
    chk(q, {24'h00_0000, e});
end
endtask
// counts the record ticks over 256 playback ticks
task run_ticks(input integer ec, input integer em);
begin
    core_cnt = 0;
    mod_cnt = 0;
    tick_en <= 1'b1;
    repeat (512) @(posedge CORE_CLK);
    tick_en <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    chk(core_cnt, ec);
    chk(mod_cnt, em);
end
endtask
// watchdog
initial begin
    #(100 * 20000);
    error_cnt = error_cnt + 1;
    report_and_stop;
end
// main sequence
initial begin
    repeat (4) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    @(posedge CORE_CLK);
    for (k = 8'h00; k < 8'h08; k = k + 8'h01) rd(6'h11 + k[5:0], RST[k*8+:8]);
    @(negedge CORE_CLK);
    chk(ADC_OVERSAMPLING_RATIO, 32'h0000_0080);
    chk(ADC_DSP_INSTRUCTION_BUDGET, 32'h0000_0100);
    chk(ADC_CORE_DIVIDER, 32'h0000_0001);
    chk(ADC_MODULATOR_DIVIDER, 32'h0000_0001);
    chk(DAC_DSP_UPSAMPLE_FACTOR, 32'h0000_0001);
    @(posedge CORE_CLK);
    rd(6'h05, 8'h00);
    // reserved bits dropped, upper budget staged until lower write
    wr(6'h11, 8'hFF);
    rd(6'h11, 8'h0F);
    wr(6'h17, 8'hFF);
    rd(6'h17, 8'h0F);
    wr(6'h18, 8'hFF);
    rd(6'h18, 8'h00);
    wr(6'h15, 8'hFF);
    rd(6'h15, 8'h7F);
    rd(6'h1F, 8'h01);
    wr(6'h16, 8'hFF);
    @(negedge CORE_CLK);
    chk(ADC_DSP_INSTRUCTION_BUDGET, 32'h0000_7FFF);
    @(posedge CORE_CLK);
    DAC_DSP_ACTIVE <= 1'b1;
    ADC_DSP_ACTIVE <= 1'b1;
    // every factor code, ratio and divider sweep
    for (k = 8'h00; k < 8'h10; k = k + 8'h01) begin
        wr(6'h11, k);
        wr(6'h17, k);
        wr(6'h14, k * 8'h11);
        wr(6'h12, k * 8'h08);
        wr(6'h13, k * 8'h08 + 8'h07);
        @(negedge CORE_CLK);
        chk(DAC_DSP_UPSAMPLE_FACTOR, (k == 8'h00) ? 32'h0000_0010 : k);
        chk(ADC_DSP_DOWNSAMPLE_FACTOR, (k == 8'h00) ? 32'h0000_0010 : k);
        chk(ADC_OVERSAMPLING_RATIO, (k == 8'h00) ? 32'h0000_0100 : k * 32'h0000_0011);
        chk(ADC_CORE_DIVIDER, (k == 8'h00) ? 32'h0000_0080 : k * 32'h0000_0008);
        chk(ADC_MODULATOR_DIVIDER, k * 32'h0000_0008 + 32'h0000_0007);
        @(posedge CORE_CLK);
    end
    // budget zero code, discarded stage, empty byte enable, replaced stage
    wr(6'h15, 8'h00);
    wr(6'h16, 8'h00);
    @(negedge CORE_CLK);
    chk(ADC_DSP_INSTRUCTION_BUDGET, 32'h0000_8000);
    @(posedge CORE_CLK);
    wr(6'h15, 8'h12);
    wr(6'h14, 8'h80);
    rd(6'h15, 8'h00);
    wr(6'h16, 8'h34);
    wr(6'h15, 8'h22);
    bus(1'b1, 6'h13, 8'h55, 1'b0);
    rd(6'h13, 8'h7F);
    wr(6'h16, 8'h56);
    @(negedge CORE_CLK);
    chk(ADC_DSP_INSTRUCTION_BUDGET, 32'h0000_0056);
    @(posedge CORE_CLK);
    wr(6'h15, 8'h05);
    wr(6'h15, 8'h03);
    rd(6'h15, 8'h03);
    wr(6'h16, 8'h00);
    @(negedge CORE_CLK);
    chk(ADC_DSP_INSTRUCTION_BUDGET, 32'h0000_0300);
    @(posedge CORE_CLK);
    // consistent record setup: ratio 64, decimation 4, budget 64
    wr(6'h17, 8'h04);
    wr(6'h14, 8'h40);
    wr(6'h15, 8'h00);
    wr(6'h16, 8'h40);
    wr(6'h11, 8'h02);
    @(negedge CORE_CLK);
    chk(ADC_OVERSAMPLING_RATIO, 32'h0000_0040);
    chk(ADC_DSP_DOWNSAMPLE_FACTOR, 32'h0000_0004);
    chk(ADC_DSP_INSTRUCTION_BUDGET, 32'h0000_0040);
    chk(DAC_DSP_UPSAMPLE_FACTOR, 32'h0000_0002);
    @(posedge CORE_CLK);
    // dividers powered, then powered down and following playback
    wr(6'h12, 8'h83);
    wr(6'h13, 8'h80);
    rd(6'h1F, 8'h1E);
    run_ticks(32'h0000_0055, 32'h0000_0002);
    wr(6'h12, 8'h03);
    wr(6'h13, 8'h00);
    run_ticks(32'h0000_0100, 32'h0000_0100);
    DAC_DSP_ACTIVE <= 1'b0;
    ADC_DSP_ACTIVE <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk(DAC_DSP_UPSAMPLE_FACTOR, 32'h0000_0001);
    chk(ADC_DSP_DOWNSAMPLE_FACTOR, 32'h0000_0001);
    report_and_stop;
end
endmodule // tb
